// *** logic/touch_key_ctrl.sv ***
// Mode, burst sequencing and output control of the touch-key controller
// Function
// - Capture all six option pins at power-up and after every reset.
// - Drive reset pin low while the device resets itself.
// - Bursts run group A (keys 1-4) then group B (keys 5-8).
// - Skip burst B when no key of 5 to 8 is implemented.
// - Standard low power inserts a sleep window after the last burst.
// - No sleep while a detection confirmation is in progress.
// - After an interrupt report, no sleep until a host command.
// - No sleep between a host write frame and its read frame.
// - Free-run-in-detect skips sleep while any key is touched.
// - Deep sleep halts until any bus frame or a reset.
// - A frame that wakes the device is not acknowledged.
// - Mode pin high selects stand-alone, low selects slave mode.
// - Individual outputs 1-6 are active high while the key is touched; outputs 7 and 8 float then and drive low otherwise.
// - Key outputs float while the device is in reset.
// - Lockout pin low disables, high enables global locking lockout.
// - Binary-coded output always enables lockout.
// - Low-power pin high inserts a 100 ms sleep, low runs freely.
// - Timeout pins set stuck limit: infinite, 60 s, 20 s, 10 s.
// - Format pin low one output per key, high binary code.
// - Binary code is 0 released, key number 1-7, 1000 for key 8.
// - Slave mode has five outputs, reset 0, changed by set command.
// - Slave mode reports every key change on the interrupt output.
// - Interrupt pulses low on key change or recalibration.
// - Slave address is 0x28 with low three bits from options.
`include "touch_key_map.svh"

module touch_key_ctrl #(
    parameter int unsigned TICK_CYCLES = `TK_TICK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [5:0] option_pins_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic self_reset_req_i,
    input wire logic [7:0] key_implemented_i,
    input wire logic [7:0] key_touched_i,
    input wire logic key_event_i,
    input wire logic detect_confirm_filter_i,
    input wire logic burst_done_i,
    output logic burst_start_o,
    output logic burst_group_o,
    output logic sleep_o,
    output logic deep_sleep_o,
    input wire touch_key_pkg::lp_mode_e lp_mode_i,
    input wire logic [7:0] sleep_ticks_i,
    input wire logic deep_sleep_req_i,
    input wire logic [15:0] stuck_limit_i,
    input wire logic host_cmd_i,
    input wire logic write_frame_done_i,
    input wire logic read_frame_done_i,
    input wire logic frame_seen_i,
    output logic frame_nack_o,
    input wire logic gpio_set_i,
    input wire logic [4:0] gpio_data_i,
    output logic [4:0] gpio_o,
    output logic [4:0] gpio_oe_o,
    output logic irq_o,
    output logic irq_oe_o,
    output logic [7:0] key_state_outputs_o,
    output logic [7:0] key_state_oe_o,
    output logic [7:0] stuck_recal_o,
    output logic standalone_o,
    output logic [6:0] slave_addr_o
);
    import touch_key_pkg::*;

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [7:0] RST_HOLD = 8'(`TK_RST_HOLD_CYC);
    localparam logic [7:0] IRQ_PULSE = 8'(`TK_IRQ_PULSE_CYC);

    // Lowest touched key as a number 1..8, zero when none
    function automatic logic [3:0] lowest_key(input logic [7:0] keys);
        lowest_key = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (keys[i]) begin
                lowest_key = 4'(i + 1);
            end
        end
    endfunction : lowest_key

    // ------------------------------------------------------------------
    // Internal reset, option capture and tick
    // ------------------------------------------------------------------
    logic in_reset_reg, in_reset_next;
    logic [7:0] rst_cnt_reg, rst_cnt_next;
    logic [5:0] opt_reg, opt_next;
    logic [15:0] tick_cnt_reg, tick_cnt_next;
    logic tick_en;

    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        if (self_reset_req_i && rst_cnt_reg == 8'h00) begin
            rst_cnt_next = RST_HOLD;
        end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_next = rst_cnt_reg - 8'h01;
        end
        in_reset_next = !rst_pin_i || rst_cnt_next != 8'h00;
        // Options are sampled as the internal reset ends
        opt_next = in_reset_reg ? option_pins_i : opt_reg;
        tick_cnt_next = (tick_cnt_reg == TICK_LAST) ? 16'h0000
                                                    : tick_cnt_reg + 16'h0001;
        tick_en = tick_cnt_reg == TICK_LAST;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_reset_reg <= 1'b1;
            rst_cnt_reg <= 8'h00;
            opt_reg <= `TK_OPT_RST;
            tick_cnt_reg <= 16'h0000;
        end else begin
            in_reset_reg <= in_reset_next;
            rst_cnt_reg <= rst_cnt_next;
            opt_reg <= opt_next;
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    logic standalone, opt_lock, opt_lp, opt_fmt, lock_en;
    logic [15:0] stuck_limit;
    assign standalone = opt_reg[`TK_OPT_MODE];
    assign opt_lock = opt_reg[`TK_OPT_LOCK];
    assign opt_lp = opt_reg[`TK_OPT_LP];
    assign opt_fmt = opt_reg[`TK_OPT_FMT];
    assign lock_en = opt_fmt || opt_lock;
    assign standalone_o = standalone;
    assign slave_addr_o = {`TK_ADDR_BASE_HI,
                           opt_reg[`TK_OPT_ADDR_LO +: 3]};
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = rst_cnt_reg != 8'h00;

    always_comb begin
        if (!standalone) begin
            stuck_limit = stuck_limit_i;
        end else begin
            case ({opt_reg[`TK_OPT_TO0], opt_reg[`TK_OPT_TO1]})
                2'b01: stuck_limit = `TK_STUCK_60S_MS;
                2'b10: stuck_limit = `TK_STUCK_20S_MS;
                2'b11: stuck_limit = `TK_STUCK_10S_MS;
                default: stuck_limit = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Stuck-key timers
    // ------------------------------------------------------------------
    logic [7:0] active_touch;
    assign active_touch = key_touched_i & key_implemented_i;

    for (genvar k = 0; k < 8; k++) begin : g_hold
        key_hold_timer u_timer (
            .mclk_i(mclk_i),
            .arst_n_i(arst_n_i),
            .clear_i(in_reset_reg),
            .tick_i(tick_en),
            .touched_i(active_touch[k]),
            .limit_i(stuck_limit),
            .expire_o(stuck_recal_o[k])
        );
    end

    // ------------------------------------------------------------------
    // Burst and sleep sequencer
    // ------------------------------------------------------------------
    seq_state_e seq_reg, seq_next;
    logic [15:0] sleep_cnt_reg, sleep_cnt_next;
    logic start_reg, start_next, group_reg, group_next;
    logic cmd_open_reg, cmd_open_next;
    logic deep_pend_reg, deep_pend_next;
    logic irq_hold_reg;
    logic group_b_used, lp_on, free_run, sleep_ok;
    logic [15:0] sleep_len;

    assign group_b_used = |key_implemented_i[7:4];
    assign free_run = !standalone && lp_mode_i == LP_FREE_RUN;
    assign lp_on = standalone ? opt_lp
                 : (lp_mode_i == LP_STD || free_run);
    assign sleep_len = standalone ? `TK_SLEEP_STD_MS : {8'h00, sleep_ticks_i};
    assign sleep_ok = lp_on && sleep_len != 16'h0000
                   && !detect_confirm_filter_i
                   && !irq_hold_reg
                   && !cmd_open_reg
                   && !(free_run && |active_touch);

    always_comb begin
        seq_next = seq_reg;
        sleep_cnt_next = sleep_cnt_reg;
        start_next = 1'b0;
        group_next = group_reg;
        cmd_open_next = cmd_open_reg;
        deep_pend_next = deep_pend_reg;
        if (read_frame_done_i) begin
            cmd_open_next = 1'b0;
        end
        if (write_frame_done_i) begin
            cmd_open_next = 1'b1;
        end
        if (deep_sleep_req_i && !standalone) begin
            deep_pend_next = 1'b1;
        end
        case (seq_reg)
            SEQ_RESET: begin
                seq_next = SEQ_BURST_A;
                start_next = 1'b1;
                group_next = 1'b0;
            end
            SEQ_BURST_A, SEQ_BURST_B: begin
                if (burst_done_i) begin
                    if (seq_reg == SEQ_BURST_A && group_b_used) begin
                        seq_next = SEQ_BURST_B;
                        start_next = 1'b1;
                        group_next = 1'b1;
                    end else if (deep_pend_reg) begin
                        seq_next = SEQ_DEEP;
                        deep_pend_next = 1'b0;
                    end else if (sleep_ok) begin
                        seq_next = SEQ_SLEEP;
                        sleep_cnt_next = sleep_len;
                    end else begin
                        seq_next = SEQ_BURST_A;
                        start_next = 1'b1;
                        group_next = 1'b0;
                    end
                end
            end
            SEQ_SLEEP: begin
                if (frame_seen_i
                    || (tick_en && sleep_cnt_reg <= 16'h0001)) begin
                    seq_next = SEQ_BURST_A;
                    start_next = 1'b1;
                    group_next = 1'b0;
                end else if (tick_en) begin
                    sleep_cnt_next = sleep_cnt_reg - 16'h0001;
                end
            end
            SEQ_DEEP: begin
                if (frame_seen_i) begin
                    seq_next = SEQ_BURST_A;
                    start_next = 1'b1;
                    group_next = 1'b0;
                end
            end
            default: seq_next = SEQ_RESET;
        endcase
        if (in_reset_reg) begin
            seq_next = SEQ_RESET;
            start_next = 1'b0;
            cmd_open_next = 1'b0;
            deep_pend_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_reg <= SEQ_RESET;
            sleep_cnt_reg <= 16'h0000;
            start_reg <= 1'b0;
            group_reg <= 1'b0;
            cmd_open_reg <= 1'b0;
            deep_pend_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            sleep_cnt_reg <= sleep_cnt_next;
            start_reg <= start_next;
            group_reg <= group_next;
            cmd_open_reg <= cmd_open_next;
            deep_pend_reg <= deep_pend_next;
        end
    end

    assign burst_start_o = start_reg;
    assign burst_group_o = group_reg;
    assign sleep_o = seq_reg == SEQ_SLEEP;
    assign deep_sleep_o = seq_reg == SEQ_DEEP;
    assign frame_nack_o = frame_seen_i && (sleep_o || deep_sleep_o);

    // ------------------------------------------------------------------
    // Interrupt and general-purpose outputs
    // ------------------------------------------------------------------
    logic irq_hold_next;
    logic [7:0] irq_cnt_reg, irq_cnt_next;
    logic [4:0] gpio_reg, gpio_next;
    logic irq_event;
    assign irq_event = !standalone && !in_reset_reg
                    && (key_event_i || |stuck_recal_o);

    always_comb begin
        irq_hold_next = irq_hold_reg;
        irq_cnt_next = irq_cnt_reg;
        gpio_next = gpio_reg;
        if (irq_cnt_reg != 8'h00) begin
            irq_cnt_next = irq_cnt_reg - 8'h01;
        end
        if (host_cmd_i) begin
            irq_hold_next = 1'b0;
        end
        if (irq_event) begin
            irq_cnt_next = IRQ_PULSE;
            irq_hold_next = 1'b1;
        end
        if (gpio_set_i && !standalone) begin
            gpio_next = gpio_data_i;
        end
        if (in_reset_reg) begin
            irq_hold_next = 1'b0;
            irq_cnt_next = 8'h00;
            gpio_next = `TK_GPIO_RST;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_hold_reg <= 1'b0;
            irq_cnt_reg <= 8'h00;
            gpio_reg <= `TK_GPIO_RST;
        end else begin
            irq_hold_reg <= irq_hold_next;
            irq_cnt_reg <= irq_cnt_next;
            gpio_reg <= gpio_next;
        end
    end

    assign irq_o = 1'b0;
    assign irq_oe_o = irq_cnt_reg != 8'h00;
    assign gpio_o = gpio_reg;
    assign gpio_oe_o = {5{!standalone && !in_reset_reg}};

    // ------------------------------------------------------------------
    // Lockout and stand-alone key outputs
    // ------------------------------------------------------------------
    logic [3:0] locked_reg, locked_next;
    logic [7:0] kout_reg, kout_next, koe_reg, koe_next, shown;

    always_comb begin
        if (locked_reg != 4'h0 && active_touch[3'(locked_reg - 4'h1)]) begin
            locked_next = locked_reg;
        end else begin
            locked_next = lowest_key(active_touch);
        end
        shown = (locked_next == 4'h0) ? 8'h00
              : 8'(8'h01 << (locked_next - 4'h1));
        if (!lock_en) begin
            shown = active_touch;
        end
        kout_next = 8'h00;
        koe_next = 8'h00;
        if (in_reset_reg || !standalone) begin
            koe_next = 8'h00;
        end else if (opt_fmt) begin
            kout_next = {4'h0, locked_next};
            koe_next = 8'h0f;
        end else begin
            kout_next = shown;
            koe_next = {~shown[7:6], 6'h3f};
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            locked_reg <= 4'h0;
            kout_reg <= 8'h00;
            koe_reg <= 8'h00;
        end else begin
            locked_reg <= locked_next;
            kout_reg <= kout_next;
            koe_reg <= koe_next;
        end
    end

    assign key_state_outputs_o = kout_reg;
    assign key_state_oe_o = koe_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    opt_capture_a: assert property (
        in_reset_reg && !in_reset_next |=> opt_reg == $past(option_pins_i))
        else $error("options not captured at reset release");
    reset_drive_a: assert property (
        self_reset_req_i && rst_cnt_reg == 8'h00 |=> rst_pin_oe_o [*8])
        else $error("reset pin not held low during self reset");
    burst_b_a: assert property (
        burst_start_o && burst_group_o |-> group_b_used
        && $past(seq_reg) == SEQ_BURST_A)
        else $error("burst B out of order or not implemented");
    sleep_gate_a: assert property (
        $rose(sleep_o) |-> $past(!detect_confirm_filter_i && !irq_hold_reg
        && !cmd_open_reg && lp_on))
        else $error("sleep entered while blocked");
    free_run_a: assert property (
        $rose(sleep_o) |-> !$past(free_run && |active_touch))
        else $error("sleep entered with a key touched");
    deep_hold_a: assert property (
        deep_sleep_o && !frame_seen_i && !in_reset_reg |=> deep_sleep_o)
        else $error("deep sleep left without a frame");
    wake_nack_a: assert property (
        frame_seen_i && (sleep_o || deep_sleep_o) |-> frame_nack_o
        ##1 seq_reg == SEQ_BURST_A || in_reset_reg)
        else $error("wake frame acknowledged");
    float_reset_a: assert property (
        in_reset_reg |=> key_state_oe_o == 8'h00)
        else $error("key outputs driven in reset");
    bcd_code_a: assert property (
        key_state_oe_o == 8'h0f |-> key_state_outputs_o <= 8'h08)
        else $error("binary code out of range");
    gpio_hold_a: assert property (
        !gpio_set_i && !in_reset_reg |=> $stable(gpio_o))
        else $error("general output changed without command");
    irq_pulse_a: assert property (
        irq_event |=> irq_oe_o [*3])
        else $error("interrupt not pulsed on key event");

    deep_wake_c: cover property (deep_sleep_o ##1 !deep_sleep_o);
    sleep_run_c: cover property (sleep_o ##1 burst_start_o);
    two_burst_c: cover property (burst_start_o && burst_group_o);
    bcd_key8_c: cover property (key_state_outputs_o == 8'h08);
endmodule : touch_key_ctrl

// *** logic/touch_key_map.svh ***
// Constants of the touch-key mode and output controller
`ifndef TOUCH_KEY_MAP_SVH
`define TOUCH_KEY_MAP_SVH

// ----------------------------------------------------------------------
// Option pin positions
// ----------------------------------------------------------------------
`define TK_OPT_MODE 0
`define TK_OPT_LOCK 1
`define TK_OPT_LP 2
`define TK_OPT_TO0 3
`define TK_OPT_TO1 4
`define TK_OPT_FMT 5
`define TK_OPT_ADDR_LO 1
`define TK_ADDR_BASE_HI 4'h5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TK_OPT_RST 6'h00
`define TK_GPIO_RST 5'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TK_CLK_MHZ 25
`define TK_TICK_NS 1000000
`define TK_TICK_CYCLES (`TK_TICK_NS * `TK_CLK_MHZ / 1000)
`define TK_SLEEP_STD_MS 16'd100
`define TK_STUCK_60S_MS 16'd60000
`define TK_STUCK_20S_MS 16'd20000
`define TK_STUCK_10S_MS 16'd10000
`define TK_RST_HOLD_NS 1000
`define TK_RST_HOLD_CYC ((`TK_RST_HOLD_NS * `TK_CLK_MHZ + 999) / 1000)
`define TK_IRQ_PULSE_NS 2000
`define TK_IRQ_PULSE_CYC ((`TK_IRQ_PULSE_NS * `TK_CLK_MHZ + 999) / 1000)

`endif

// *** logic/touch_key_pkg.sv ***
// Types of the touch-key mode and output controller
package touch_key_pkg;
    typedef enum logic [2:0] {
        SEQ_RESET, SEQ_BURST_A, SEQ_BURST_B, SEQ_SLEEP, SEQ_DEEP
    } seq_state_e;
    typedef enum logic [1:0] {
        LP_OFF, LP_STD, LP_FREE_RUN, LP_DEEP
    } lp_mode_e;
endpackage : touch_key_pkg

// *** logic/key_hold_timer.sv ***
// Per-key continuous-touch timer raising a recalibration pulse
module key_hold_timer (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic touched_i,
    input wire logic [15:0] limit_i,
    output logic expire_o
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic expire_reg;
    logic expire_next;

    always_comb begin
        cnt_next = cnt_reg;
        expire_next = 1'b0;
        if (clear_i || !touched_i || limit_i == 16'h0000) begin
            cnt_next = 16'h0000;
        end else if (tick_i) begin
            if (cnt_reg + 16'h0001 >= limit_i) begin
                cnt_next = 16'h0000;
                expire_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 16'h0000;
            expire_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            expire_reg <= expire_next;
        end
    end

    assign expire_o = expire_reg;
endmodule : key_hold_timer

// *** verification/host_model.sv ***
// Two-wire bus master model issuing frames and commands
module host_model (
    input wire logic mclk_i,
    input wire logic frame_nack_i,
    output logic frame_seen_o,
    output logic cmd_o,
    output logic wr_done_o,
    output logic rd_done_o,
    output logic set_o,
    output logic [4:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int tries;
    initial {frame_seen_o, cmd_o, wr_done_o, rd_done_o, set_o, data_o} = '0;
    task automatic send_frame;
        tries = 0;
        do begin
            @(posedge mclk_i) frame_seen_o <= 1'b1;
            @(posedge mclk_i) frame_seen_o <= 1'b0;
            tries++;
        end while (frame_nack_i === 1'b1 && tries < 8);
    endtask : send_frame
    // Write frame, then the read frame after gap cycles
    task automatic command(input logic set, input logic [4:0] d,
                           input int gap);
        send_frame();
        @(posedge mclk_i) {cmd_o, wr_done_o, set_o, data_o} <= {2'b11, set, d};
        @(posedge mclk_i) {cmd_o, wr_done_o, set_o} <= 3'b000;
        repeat (gap) @(posedge mclk_i);
        rd_done_o <= 1'b1;
        @(posedge mclk_i) rd_done_o <= 1'b0;
    endtask : command
endmodule : host_model

// *** verification/tb.sv ***
// Self-checking bench of the touch-key mode and output controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import touch_key_pkg::*;
    localparam int TICKS = 10;
    logic mclk_i, arst_n_i, ext_rst_n, self_reset_req_i, key_event_i;
    logic detect_confirm_filter_i, burst_done_i, deep_sleep_req_i;
    logic host_cmd_i, write_frame_done_i, read_frame_done_i, frame_seen_i;
    logic gpio_set_i, rst_pin_o, rst_pin_oe_o, frame_nack_o, irq_o;
    logic burst_start_o, burst_group_o, sleep_o, deep_sleep_o;
    logic irq_oe_o, standalone_o, last_grp;
    logic [4:0] gpio_data_i, gpio_o, gpio_oe_o;
    logic [5:0] option_pins_i;
    logic [6:0] slave_addr_o;
    logic [7:0] key_implemented_i, key_touched_i, sleep_ticks_i;
    logic [7:0] key_state_outputs_o, key_state_oe_o, stuck_recal_o;
    logic [15:0] stuck_limit_i, cnt;
    lp_mode_e lp_mode_i;
    wire rst_pin_i;
    integer seed = 32'h5c79bea0;
    int n_errors = 0;
    int comparisons = 0;
    int cnt_b = 0;
    int n_recal = 0;
    logic [7:0] lk_in[4] = '{8'h04, 8'h14, 8'h10, 8'h30};
    logic [7:0] lk_exp[4] = '{8'h04, 8'h04, 8'h10, 8'h10};

    // Reset pin has a pull-up; the device pulls it low
    assign rst_pin_i = ext_rst_n & ~rst_pin_oe_o;
    always #20 mclk_i = ~mclk_i;

    touch_key_ctrl #(.TICK_CYCLES(TICKS)) uut (.*);
    host_model host (.mclk_i(mclk_i), .frame_nack_i(frame_nack_o),
        .frame_seen_o(frame_seen_i), .cmd_o(host_cmd_i),
        .wr_done_o(write_frame_done_i), .rd_done_o(read_frame_done_i),
        .set_o(gpio_set_i), .data_o(gpio_data_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic touch(input logic [7:0] t);
        @(posedge mclk_i) key_touched_i <= t;
        repeat (4) @(negedge mclk_i);
    endtask : touch

    task automatic wait_hi(ref logic s, input int n);
        cnt = 0;
        while (s !== 1'b1 && cnt < n) begin
            @(negedge mclk_i);
            cnt++;
        end
    endtask : wait_hi

    task automatic hold_len(ref logic s);
        cnt = 0;
        while (s === 1'b1 && cnt < 3000) begin
            @(negedge mclk_i);
            cnt++;
        end
    endtask : hold_len

    task automatic no_sleep(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge mclk_i);
            if (sleep_o === 1'b1) cnt++;
        end
    endtask : no_sleep

    task automatic rst(input logic [5:0] opt, input logic [7:0] impl);
        @(posedge mclk_i) arst_n_i <= 1'b0;
        ext_rst_n <= 1'b0;
        option_pins_i <= opt;
        key_implemented_i <= impl;
        key_touched_i <= 8'h00;
        repeat (3) @(negedge mclk_i);
        chk(key_state_oe_o, 8'h00);
        last_grp = 1'b1;
        @(posedge mclk_i) arst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        ext_rst_n <= 1'b1;
        repeat (4) @(negedge mclk_i);
    endtask : rst

    // Burst engine stand-in: finishes each burst three cycles on
    always @(posedge mclk_i) begin
        burst_done_i <= burst_start_o !== 1'b1 && cnt_b == 1;
        if (stuck_recal_o[0] === 1'b1) n_recal++;
        if (rst_pin_i !== 1'b1 || arst_n_i !== 1'b1) begin
            // Any reset restarts the sequence with group A
            last_grp = 1'b1;
            cnt_b = 0;
        end else if (burst_start_o === 1'b1) begin
            chk(burst_group_o, !last_grp && |key_implemented_i[7:4]);
            last_grp = burst_group_o;
            cnt_b = 3;
        end else if (cnt_b > 0) begin
            cnt_b--;
        end
    end

    initial begin
        {mclk_i, arst_n_i, ext_rst_n, self_reset_req_i, key_event_i} = '0;
        {detect_confirm_filter_i, burst_done_i, deep_sleep_req_i} = '0;
        {option_pins_i, key_implemented_i, key_touched_i} = '0;
        {sleep_ticks_i, stuck_limit_i, last_grp} = {8'd5, 16'd0, 1'b1};
        lp_mode_i = LP_STD;
        rst(6'h01, 8'hff);
        chk(standalone_o, 1'b1);
        repeat (20) begin
            touch(8'($random(seed)));
            chk(key_state_outputs_o, key_touched_i);
            chk(key_state_oe_o, {~key_touched_i[7:6], 6'h3f});
        end
        rst(6'h03, 8'hff);
        foreach (lk_in[i]) begin
            touch(lk_in[i]);
            chk(key_state_outputs_o, lk_exp[i]);
        end
        rst(6'h21, 8'hff);
        for (int k = 1; k <= 8; k++) begin
            touch(8'h01 << (k - 1));
            chk(key_state_outputs_o[3:0], k[3:0]);
            chk(key_state_oe_o, 8'h0f);
        end
        touch(8'h00);
        chk(key_state_outputs_o[3:0], 4'h0);
        touch(8'h06);
        chk(key_state_outputs_o[3:0], 4'h2);
        rst(6'h01, 8'h0f);
        repeat (60) @(posedge mclk_i);
        rst(6'h05, 8'hff);
        wait_hi(sleep_o, 300);
        chk(last_grp, 1'b1);
        hold_len(sleep_o);
        chk(cnt >= 16'd985 && cnt <= 16'd1010, 1'b1);
        wait_hi(sleep_o, 300);
        host.send_frame();
        chk(16'(host.tries), 16'd2);
        @(posedge mclk_i) detect_confirm_filter_i <= 1'b1;
        no_sleep(300);
        chk(cnt, 16'd0);
        @(posedge mclk_i) detect_confirm_filter_i <= 1'b0;
        rst(6'h14, 8'hff);
        chk(standalone_o, 1'b0);
        chk(slave_addr_o, 7'h2a);
        chk({gpio_oe_o, gpio_o, key_state_oe_o}, 18'h3e000);
        chk({irq_o, rst_pin_o}, 2'b00);
        host.command(1'b1, 5'h15, 0);
        repeat (2) @(negedge mclk_i);
        chk(gpio_o, 5'h15);
        @(posedge mclk_i) key_event_i <= 1'b1;
        @(posedge mclk_i) key_event_i <= 1'b0;
        wait_hi(irq_oe_o, 3);
        chk(irq_oe_o, 1'b1);
        hold_len(irq_oe_o);
        chk(cnt, 16'd50);
        no_sleep(300);
        chk(cnt, 16'd0);
        fork
            host.command(1'b0, 5'h00, 200);
            no_sleep(150);
        join
        chk(cnt, 16'd0);
        wait_hi(sleep_o, 300);
        chk(sleep_o, 1'b1);
        hold_len(sleep_o);
        chk(cnt >= 16'd40 && cnt <= 16'd51, 1'b1);
        @(posedge mclk_i) lp_mode_i <= LP_FREE_RUN;
        key_touched_i <= 8'h01;
        no_sleep(300);
        chk(cnt, 16'd0);
        // Key 1 held: three-tick limit gives one recalibration per 30 cycles
        @(posedge mclk_i) stuck_limit_i <= 16'd3;
        n_recal = 0;
        repeat (300) @(negedge mclk_i);
        chk(n_recal >= 9 && n_recal <= 10, 1'b1);
        @(posedge mclk_i) deep_sleep_req_i <= 1'b1;
        @(posedge mclk_i) deep_sleep_req_i <= 1'b0;
        wait_hi(deep_sleep_o, 300);
        repeat (200) @(negedge mclk_i);
        chk(deep_sleep_o, 1'b1);
        host.send_frame();
        #1 chk(16'(host.tries), 16'd2);
        chk(deep_sleep_o, 1'b0);
        @(posedge mclk_i) option_pins_i <= 6'h01;
        @(posedge mclk_i) self_reset_req_i <= 1'b1;
        @(posedge mclk_i) self_reset_req_i <= 1'b0;
        wait_hi(rst_pin_oe_o, 3);
        hold_len(rst_pin_oe_o);
        chk(cnt, 16'd25);
        repeat (4) @(negedge mclk_i);
        chk(standalone_o, 1'b1);
        finish_test();
    end

    initial begin
        #(40 * 30000);
        n_errors++;
        finish_test();
    end
endmodule : tb
